//--- design/rfs_ctrl_regs.sv
// rfs_ctrl_regs.sv: divider and output control words of the rf synthesizer
// assumes: host drives ser_clk, ser_data, latch_enable synchronous to ref_clk
// Overview of operation
// - numerator from bits 12..2, msb at 12
// - swallow count from bits 15..13, 0..7
// - binary count bits 19..16, host writes 2..15
// - bit 21: lock pin ground or, with rf power enabled, lock status
// - bit 23 selects default if counters
// - address 01 loads output control word
// - bit 2 enables +5 khz offset
// - bit 3 zero powers down pll and vco
// - bits 5..4 select output buffer level
// - msb first shifting, load on latch rise
// - address 00 loads divider control word
`timescale 1ns/1ps
`include "rfs_defines.svh"

module rfs_ctrl_regs
	import rfs_pkg::*;
#(
	parameter int WORD_W = `RFS_WORD_W
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        ser_clk,
	input  wire logic        ser_data,
	input  wire logic        latch_enable,
	input  wire logic        lock_detect,
	input  wire logic        ref_freq_select,
	output logic             lock_out_pin,
	output rfs_div_t         div_ctrl,
	output rfs_out_t         out_ctrl,
	output logic             rf_pll_power,
	output logic             rf_vco_power,
	output logic             fn_range_error,
	output logic             bin_range_error
);

	logic [WORD_W-1:0] word;
	logic              load;
	rfs_div_t          div_ff;
	rfs_div_t          nxt_div;
	rfs_out_t          out_ff;
	rfs_out_t          nxt_out;
	logic              lock_ff;
	logic              nxt_lock;

	function automatic logic [1:0] addr_of(input logic [WORD_W-1:0] w);
		addr_of = w[`RFS_ADDR_MSB:`RFS_ADDR_LSB];
	endfunction

	// latch strobe aimed at one control word
	function automatic logic load_to(input logic ld, input logic [WORD_W-1:0] w, input logic [1:0] a);
		load_to = ld && (addr_of(w) == a);
	endfunction

	rfs_shifter #(
		.WORD_W (WORD_W)
	) u_shifter (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.ser_clk      (ser_clk),
		.ser_data     (ser_data),
		.latch_enable (latch_enable),
		.word         (word),
		.load         (load)
	);

	always_comb begin
		nxt_div = div_ff;
		nxt_out = out_ff;
		if (load_to(load, word, `RFS_ADDR_DIV)) begin
			nxt_div.frac_numerator    = word[`RFS_FN_MSB:`RFS_FN_LSB];
			nxt_div.swallow_count     = word[`RFS_SW_MSB:`RFS_SW_LSB];
			nxt_div.binary_count      = word[`RFS_BIN_MSB:`RFS_BIN_LSB];
			nxt_div.lock_out_select   = word[`RFS_LOCK_SEL_BIT];
			nxt_div.default_if_select = word[`RFS_DEF_SEL_BIT];
		end
		if (load_to(load, word, `RFS_ADDR_OUT)) begin
			nxt_out.offset_enable   = word[`RFS_OFFSET_BIT];
			nxt_out.rf_power_enable = word[`RFS_PWR_BIT];
			nxt_out.buffer_level    = word[`RFS_LEVEL_MSB:`RFS_LEVEL_LSB];
		end
		// lock pin held at ground unless lock status is selected and rf power is enabled
		nxt_lock = div_ff.lock_out_select & lock_detect & out_ff.rf_power_enable;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_ff  <= '{default_if_select: `RFS_RST_DEF_SEL, lock_out_select: `RFS_RST_LOCK_SEL,
				binary_count: `RFS_RST_BIN, swallow_count: `RFS_RST_SW, frac_numerator: `RFS_RST_FN};
			out_ff  <= '{buffer_level: `RFS_RST_LEVEL, rf_power_enable: `RFS_RST_PWR,
				offset_enable: `RFS_RST_OFFSET};
			lock_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			out_ff  <= nxt_out;
			lock_ff <= nxt_lock;
		end
	end

	assign div_ctrl     = div_ff;
	assign out_ctrl     = out_ff;
	assign lock_out_pin = lock_ff;
	assign rf_pll_power = out_ff.rf_power_enable;
	assign rf_vco_power = out_ff.rf_power_enable;
	// flags for values the host must not program
	assign fn_range_error = ref_freq_select ? (div_ff.frac_numerator > `RFS_FN_MAX_REF1)
		: (div_ff.frac_numerator > `RFS_FN_MAX_REF0);
	assign bin_range_error = div_ff.binary_count < `RFS_BIN_MIN;

	a_div_load_fields: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.frac_numerator == $past(word[`RFS_FN_MSB:`RFS_FN_LSB])
		&& div_ff.swallow_count == $past(word[`RFS_SW_MSB:`RFS_SW_LSB]))
		else $error("divider word fields not loaded");

	a_fn_msb_pos: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.frac_numerator[10] == $past(word[`RFS_FN_MSB]))
		else $error("numerator msb not taken from its bit");

	a_fn_lsb_pos: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.frac_numerator[0] == $past(word[`RFS_FN_LSB]))
		else $error("numerator lsb not taken from its bit");

	a_fn_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load_to(load, word, `RFS_ADDR_DIV)
		|=> $stable(div_ff.frac_numerator))
		else $error("numerator changed without a divider load");

	a_fn_err_ref0: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!ref_freq_select
		|-> fn_range_error == (div_ff.frac_numerator > `RFS_FN_MAX_REF0))
		else $error("numerator range flag wrong at lower reference");

	a_fn_err_ref1: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		ref_freq_select
		|-> fn_range_error == (div_ff.frac_numerator > `RFS_FN_MAX_REF1))
		else $error("numerator range flag wrong at upper reference");

	a_swallow_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load
		|=> $stable(div_ff) && $stable(out_ff))
		else $error("control word changed without a load");

	a_swallow_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.swallow_count == $past(word[`RFS_SW_MSB:`RFS_SW_LSB]))
		else $error("swallow count not loaded");

	a_sw_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load_to(load, word, `RFS_ADDR_DIV)
		|=> $stable(div_ff.swallow_count))
		else $error("swallow count changed without a divider load");

	a_bin_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.binary_count == $past(word[`RFS_BIN_MSB:`RFS_BIN_LSB]))
		else $error("binary count not loaded");

	a_bin_msb_pos: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.binary_count[3] == $past(word[`RFS_BIN_MSB]))
		else $error("binary count msb not taken from its bit");

	a_bin_err: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		1'b1
		|-> bin_range_error == (div_ff.binary_count < `RFS_BIN_MIN))
		else $error("binary count range flag wrong");

	a_lock_ground: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!div_ff.lock_out_select
		|=> !lock_out_pin)
		else $error("lock pin not held at ground");

	a_lock_sel_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.lock_out_select == $past(word[`RFS_LOCK_SEL_BIT]))
		else $error("lock select not loaded");

	a_lock_sel_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load_to(load, word, `RFS_ADDR_DIV)
		|=> $stable(div_ff.lock_out_select))
		else $error("lock select changed without a divider load");

	a_lock_follow: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		div_ff.lock_out_select && out_ff.rf_power_enable
		|=> lock_out_pin == $past(lock_detect))
		else $error("lock pin does not follow lock status");

	a_def_sel_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> div_ff.default_if_select == $past(word[`RFS_DEF_SEL_BIT]))
		else $error("default select not loaded");

	a_def_sel_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load_to(load, word, `RFS_ADDR_DIV)
		|=> $stable(div_ff.default_if_select))
		else $error("default select changed without a divider load");

	a_out_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_OUT)
		|=> out_ff.offset_enable == $past(word[`RFS_OFFSET_BIT])
		&& out_ff.buffer_level == $past(word[`RFS_LEVEL_MSB:`RFS_LEVEL_LSB]))
		else $error("output word not loaded");

	a_addr_unused: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load && word[`RFS_ADDR_MSB]
		|=> $stable(div_ff) && $stable(out_ff))
		else $error("word with unused address changed a control word");

	a_out_addr_only: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load_to(load, word, `RFS_ADDR_OUT)
		|=> $stable(out_ff))
		else $error("output word loaded at wrong address");

	a_offset_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_OUT)
		|=> out_ff.offset_enable == $past(word[`RFS_OFFSET_BIT]))
		else $error("offset enable not loaded");

	a_power_follow: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_OUT)
		|=> rf_pll_power == $past(word[`RFS_PWR_BIT])
		&& rf_vco_power == $past(word[`RFS_PWR_BIT]))
		else $error("power enable not applied");

	a_pwr_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_OUT)
		|=> out_ff.rf_power_enable == $past(word[`RFS_PWR_BIT]))
		else $error("power enable bit not loaded");

	a_lock_off_power: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!out_ff.rf_power_enable
		|=> !lock_out_pin)
		else $error("lock pin high while powered down");

	a_level_stable: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_DIV)
		|=> $stable(out_ctrl.buffer_level))
		else $error("buffer level changed by divider load");

	a_level_load: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load_to(load, word, `RFS_ADDR_OUT)
		|=> out_ff.buffer_level == $past(word[`RFS_LEVEL_MSB:`RFS_LEVEL_LSB]))
		else $error("buffer level not loaded");

	a_level_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load_to(load, word, `RFS_ADDR_OUT)
		|=> $stable(out_ff.buffer_level))
		else $error("buffer level changed without an output load");

	a_div_addr_only: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!load_to(load, word, `RFS_ADDR_DIV)
		|=> $stable(div_ff))
		else $error("divider word loaded at wrong address");

endmodule

//--- design/rfs_defines.svh
// rfs_defines.svh: bit positions, addresses and reset values of the rf synthesizer control words
// assumes: included by bare name from the package and the design modules
`ifndef RFS_DEFINES_SVH
`define RFS_DEFINES_SVH

`define RFS_WORD_W        24
`define RFS_ADDR_LSB      0
`define RFS_ADDR_MSB      1
`define RFS_ADDR_DIV      2'h0
`define RFS_ADDR_OUT      2'h1
`define RFS_FN_LSB        2
`define RFS_FN_MSB        12
`define RFS_SW_LSB        13
`define RFS_SW_MSB        15
`define RFS_BIN_LSB       16
`define RFS_BIN_MSB       19
`define RFS_LOCK_SEL_BIT  21
`define RFS_DEF_SEL_BIT   23
`define RFS_OFFSET_BIT    2
`define RFS_PWR_BIT       3
`define RFS_LEVEL_LSB     4
`define RFS_LEVEL_MSB     5
`define RFS_BIN_MIN       4'h2
`define RFS_FN_MAX_REF0   11'h77f
`define RFS_FN_MAX_REF1   11'h7af
`define RFS_RST_FN        11'h000
`define RFS_RST_SW        3'h0
`define RFS_RST_BIN       4'h2
`define RFS_RST_LOCK_SEL  1'b0
`define RFS_RST_DEF_SEL   1'b1
`define RFS_RST_OFFSET    1'b0
`define RFS_RST_PWR       1'b0
`define RFS_RST_LEVEL     2'h0

`endif

//--- design/rfs_pkg.sv
// rfs_pkg.sv: types for the rf synthesizer control words
// assumes: rfs_defines.svh on the include path
`include "rfs_defines.svh"

package rfs_pkg;

	typedef struct packed {
		logic        default_if_select;
		logic        lock_out_select;
		logic [3:0]  binary_count;
		logic [2:0]  swallow_count;
		logic [10:0] frac_numerator;
	} rfs_div_t;

	typedef struct packed {
		logic [1:0] buffer_level;
		logic       rf_power_enable;
		logic       offset_enable;
	} rfs_out_t;

	typedef enum logic [1:0] {
		RFS_IDLE  = 2'b01,
		RFS_SHIFT = 2'b10
	} rfs_state_t;

endpackage

//--- design/rfs_shifter.sv
// rfs_shifter.sv: 24-bit serial input shift register with latch-enable edge detect
// assumes: serial pins already synchronous to ref_clk
`timescale 1ns/1ps
`include "rfs_defines.svh"

module rfs_shifter
	import rfs_pkg::*;
#(
	parameter int WORD_W = `RFS_WORD_W
) (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic              ser_clk,
	input  wire logic              ser_data,
	input  wire logic              latch_enable,
	output logic [WORD_W-1:0]      word,
	output logic                   load
);

	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] nxt_shift;
	logic              sclk_ff;
	logic              le_ff;
	logic              nxt_load;
	logic              load_ff;
	rfs_state_t        state_ff;
	rfs_state_t        nxt_state;

	always_comb begin
		nxt_shift = shift_ff;
		nxt_state = state_ff;
		// msb arrives first, so shift toward the top
		if (ser_clk && !sclk_ff) begin
			nxt_shift = {shift_ff[WORD_W-2:0], ser_data};
			nxt_state = RFS_SHIFT;
		end
		nxt_load = latch_enable && !le_ff;
		if (nxt_load) begin
			nxt_state = RFS_IDLE;
		end
		case (state_ff)
			RFS_IDLE:  ;
			RFS_SHIFT: ;
			default:   nxt_state = RFS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_ff <= '0;
			sclk_ff  <= 1'b0;
			le_ff    <= 1'b0;
			load_ff  <= 1'b0;
			state_ff <= RFS_IDLE;
		end else begin
			shift_ff <= nxt_shift;
			sclk_ff  <= ser_clk;
			le_ff    <= latch_enable;
			load_ff  <= nxt_load;
			state_ff <= nxt_state;
		end
	end

	assign word = shift_ff;
	assign load = nxt_load;

	a_load_one_cycle: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		load |=> !load)
		else $error("latch load lasted more than one cycle");

	a_shift_msb_first: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(ser_clk && !sclk_ff) |=> (shift_ff[0] == $past(ser_data)
		&& shift_ff[WORD_W-1:1] == $past(shift_ff[WORD_W-2:0])))
		else $error("serial bit not shifted in at the bottom");

endmodule

//--- verification/rfs_host_model.sv
// rfs_host_model.sv: host side of the three-wire serial write link
// assumes: ref_clk from the bench; each serial clock phase lasts one ref_clk cycle
`timescale 1ns/1ps

module rfs_host_model (
	input  wire logic ref_clk,
	output logic      ser_clk,
	output logic      ser_data,
	output logic      latch_enable
);
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		latch_enable = 1'b0;
	end

	// msb first, 24 rising edges, then latch rise
	// words come whole from the bench with fixed bits as mapped
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			@(posedge ref_clk) #1 ser_clk = 1'b0;
			ser_data = w[i];
			@(posedge ref_clk) #1 ser_clk = 1'b1;
		end
		@(posedge ref_clk) #1 ser_clk = 1'b0;
		// data line no longer meaningful after the frame
		ser_data = ~w[0];
		latch_enable = 1'b1;
		@(posedge ref_clk);
		@(posedge ref_clk) #1 latch_enable = 1'b0;
	endtask
endmodule

//--- verification/rfs_ctrl_regs_test.sv
// rfs_ctrl_regs_test.sv: self-checking bench for the rf synthesizer control words
// assumes: rfs_host_model writes the serial link, bench drives the analog-side levels
`timescale 1ns/1ps

module rfs_ctrl_regs_test
	import rfs_pkg::*;
;
	typedef struct {
		logic [23:0] w;
		rfs_div_t    d;
		rfs_out_t    o;
		logic        p;
	} rfs_row_t;

	localparam rfs_div_t DR = '{1'b1, 1'b0, 4'h2, 3'h0, 11'h000};
	localparam rfs_div_t DA = '{1'b0, 1'b1, 4'hf, 3'h7, 11'h77f};
	localparam rfs_div_t DB = '{1'b1, 1'b0, 4'h2, 3'h0, 11'h7af};
	localparam rfs_div_t DC = '{1'b1, 1'b1, 4'h5, 3'h2, 11'h001};

	logic     ref_clk = 1'b0;
	logic     arst_n;
	logic     ser_clk;
	logic     ser_data;
	logic     latch_enable;
	logic     lock_detect;
	logic     ref_freq_select;
	logic     lock_out_pin;
	rfs_div_t div_ctrl;
	rfs_out_t out_ctrl;
	logic     rf_pll_power;
	logic     rf_vco_power;
	logic     fn_range_error;
	logic     bin_range_error;
	int       fails = 0;
	int       checks_done = 0;
	int       cyc = 0;

	rfs_row_t rows [7] = '{
		'{24'h6ffdfc, DA, 4'h0, 1'b0},
		'{24'h68aa7d, DA, 4'hf, 1'b1},
		'{24'h68aa51, DA, 4'h4, 1'b0},
		'{24'hc21ebc, DB, 4'h4, 1'b0},
		'{24'h68aa69, DB, 4'ha, 1'b0},
		'{24'he54004, DC, 4'ha, 1'b1},
		'{24'h68aa45, DC, 4'h1, 1'b0}
	};

	always #20 ref_clk = ~ref_clk;

	rfs_host_model u_rfs_host_model (
		.ref_clk      (ref_clk),
		.ser_clk      (ser_clk),
		.ser_data     (ser_data),
		.latch_enable (latch_enable)
	);

	rfs_ctrl_regs u_rfs_ctrl_regs (
		.ref_clk         (ref_clk),
		.arst_n          (arst_n),
		.ser_clk         (ser_clk),
		.ser_data        (ser_data),
		.latch_enable    (latch_enable),
		.lock_detect     (lock_detect),
		.ref_freq_select (ref_freq_select),
		.lock_out_pin    (lock_out_pin),
		.div_ctrl        (div_ctrl),
		.out_ctrl        (out_ctrl),
		.rf_pll_power    (rf_pll_power),
		.rf_vco_power    (rf_vco_power),
		.fn_range_error  (fn_range_error),
		.bin_range_error (bin_range_error)
	);

	task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			end_sim();
		end
	end

	initial begin
		arst_n = 1'b0;
		lock_detect = 1'b1;
		ref_freq_select = 1'b1;
		repeat (20) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		chk("div", DR, div_ctrl);
		chk("out", 4'h0, out_ctrl);
		chk("pin", 1'b0, lock_out_pin);
		$display("reset test done");
		foreach (rows[i]) begin
			u_rfs_host_model.send(rows[i].w);
			@(posedge ref_clk);
			#1 chk("div", rows[i].d, div_ctrl);
			chk("out", rows[i].o, out_ctrl);
			chk("pin", rows[i].p, lock_out_pin);
			chk("pwr", {2{rows[i].o.rf_power_enable}}, {rf_pll_power, rf_vco_power});
		end
		$display("table test done");
		// address 10 belongs to neither word
		u_rfs_host_model.send(24'hfffffe);
		chk("div", DC, div_ctrl);
		chk("out", 4'h1, out_ctrl);
		$display("refusal test done");
		// powered up with lock status selected, then lock lost
		u_rfs_host_model.send(24'h68aa49);
		@(posedge ref_clk);
		#1 chk("pin", 1'b1, lock_out_pin);
		lock_detect = 1'b0;
		@(posedge ref_clk);
		#1 chk("pin", 1'b0, lock_out_pin);
		lock_detect = 1'b1;
		$display("lock test done");
		u_rfs_host_model.send(24'hc21ebc);
		chk("fnerr", 1'b0, fn_range_error);
		ref_freq_select = 1'b0;
		#1 chk("fnerr", 1'b1, fn_range_error);
		// largest numerator allowed at the lower reference
		u_rfs_host_model.send(24'hc21dfc);
		chk("fnerr", 1'b0, fn_range_error);
		// binary count of 1 is outside the host's allowed range
		u_rfs_host_model.send(24'hc10000);
		chk("binerr", 1'b1, bin_range_error);
		$display("range test done");
		// reset in mid-run returns every word to its reset value
		arst_n = 1'b0;
		#1 chk("div", DR, div_ctrl);
		chk("out", 4'h0, out_ctrl);
		chk("binerr", 1'b0, bin_range_error);
		chk("pin", 1'b0, lock_out_pin);
		@(posedge ref_clk);
		#1 arst_n = 1'b1;
		u_rfs_host_model.send(24'h68aa7d);
		chk("out", 4'hf, out_ctrl);
		$display("second reset test done");
		end_sim();
	end
endmodule
